// ### logic/bsp_pkg.sv
// Shared constants and types for the burst SRAM port block
package bsp_pkg;
    // Data word and byte lane layout (widest configuration)
    localparam int DATA_W    = 36;
    localparam int LANES     = 4;
    localparam int LANE_W    = 9;
    // Pin address width; four words live behind each address
    localparam int ADDR_W    = 17;
    localparam int IDX_W     = 2;
    localparam int WADDR_W   = ADDR_W + IDX_W;
    localparam int MEM_WORDS = 2 ** WADDR_W;
    // Index of the first word and of the fourth and last word of a burst
    localparam logic [IDX_W-1:0] IDX_FIRST = 2'h0;
    localparam logic [IDX_W-1:0] IDX_LAST  = 2'h3;
    // Backdoor load entry: word address on top, data below
    localparam int LD_W      = WADDR_W + DATA_W;
    // Crossing buffer: one address bit gives two entries
    localparam int FIFO_AW   = 1;
    // Reset value of the read data register
    localparam logic [DATA_W-1:0] Q_RESET = 36'h0_0000_0000;

    // Read burst sequencer
    typedef enum logic [1:0] {
        RD_IDLE  = 2'b00,
        RD_BURST = 2'b01,
        RD_TAIL  = 2'b10
    } bsp_rd_state_t;

    // Write burst sequencer
    typedef enum logic {
        WR_IDLE  = 1'b0,
        WR_BURST = 1'b1
    } bsp_wr_state_t;
endpackage

// ### logic/bsp_buf_if.sv
// Valid/ready connection between the load port and its crossing buffer
`timescale 1ns/1ps
interface bsp_buf_if #(parameter int W = bsp_pkg::LD_W);
    logic         fill_valid;   // Producer offers a word
    logic         fill_ready;   // Buffer has room
    logic [W-1:0] fill_data;    // Offered word
    logic         drain_valid;  // Buffer holds a word
    logic         drain_ready;  // Consumer takes it
    logic [W-1:0] drain_data;   // Oldest word

    // The buffer itself
    modport buf_side (
        input  fill_valid, fill_data, drain_ready,
        output fill_ready, drain_valid, drain_data
    );
    // The logic around it
    modport user_side (
        output fill_valid, fill_data, drain_ready,
        input  fill_ready, drain_valid, drain_data
    );
endinterface

// ### logic/bsp_cdc_fifo.sv
// Two-clock buffer with gray-coded pointers
`timescale 1ns/1ps
module bsp_cdc_fifo #(
    parameter int W  = bsp_pkg::LD_W,
    parameter int AW = bsp_pkg::FIFO_AW
) (
    input  wire logic  i_wclk,
    input  wire logic  i_wrst,
    input  wire logic  i_rclk,
    input  wire logic  i_rrst,
    bsp_buf_if.buf_side bus
);
    localparam int DEPTH = 2 ** AW;

    logic [W-1:0] mem [DEPTH];     // Entry storage, written on i_wclk only
    logic [AW:0]  wb_q, wg_q;      // Write pointer, binary and gray
    logic [AW:0]  rb_q, rg_q;      // Read pointer, binary and gray
    logic [AW:0]  rg_m_q, rg_s_q;  // Read gray into write domain
    logic [AW:0]  wg_m_q, wg_s_q;  // Write gray into read domain

    // Gray to binary, used only on the synchronised copy
    function automatic logic [AW:0] g2b(input logic [AW:0] g);
        logic [AW:0] b;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction

    wire [AW:0] one_w   = {{AW{1'b0}}, 1'b1};
    wire [AW:0] wb_nx   = wb_q + one_w;
    wire [AW:0] rb_nx   = rb_q + one_w;
    wire [AW:0] fill_lv = wb_q - g2b(rg_s_q);  // Pessimistic fill level
    wire        full    = fill_lv[AW];         // Level equals DEPTH
    wire        empty   = (wg_s_q == rg_q);
    wire        wr_fire = bus.fill_valid & ~full;
    wire        rd_fire = bus.drain_ready & ~empty;

    assign bus.fill_ready  = ~full;
    assign bus.drain_valid = ~empty;
    assign bus.drain_data  = mem[rb_q[AW-1:0]];

    // Write side pointer
    always_ff @(posedge i_wclk) begin
        if (i_wrst) begin
            wb_q <= '0;
            wg_q <= '0;
        end else if (wr_fire) begin
            wb_q <= wb_nx;
            wg_q <= wb_nx ^ (wb_nx >> 1);
        end
    end

    // Entry write; no reset needed, pointers guard it
    always_ff @(posedge i_wclk) begin
        if (wr_fire) begin
            mem[wb_q[AW-1:0]] <= bus.fill_data;
        end
    end

    // Read pointer brought over by two flops
    always_ff @(posedge i_wclk) begin
        if (i_wrst) begin
            rg_m_q <= '0;
            rg_s_q <= '0;
        end else begin
            rg_m_q <= rg_q;
            rg_s_q <= rg_m_q;
        end
    end

    // Read side pointer
    always_ff @(posedge i_rclk) begin
        if (i_rrst) begin
            rb_q <= '0;
            rg_q <= '0;
        end else if (rd_fire) begin
            rb_q <= rb_nx;
            rg_q <= rb_nx ^ (rb_nx >> 1);
        end
    end

    // Write pointer brought over by two flops
    always_ff @(posedge i_rclk) begin
        if (i_rrst) begin
            wg_m_q <= '0;
            wg_s_q <= '0;
        end else begin
            wg_m_q <= wg_q;
            wg_s_q <= wg_m_q;
        end
    end
endmodule

// ### logic/bsp_sram_port.sv
// Pin-level port of the double-data-rate burst SRAM, with its array
`timescale 1ns/1ps
// What this block does
// - Byte mask sampled with its data word
// - Masked lane keeps its stored byte
// - Mask bit n governs nine-bit lane n
// - One shared address bus, taken at K
// - Address ignored when its port deselected
// - Read data driven on both edges
// - Read select low at K starts read, except on the K edge in the middle of a read burst
// - Finish burst, tristate after next K
// - Each read yields four sequential words
// - Valid flag marks data, echo aligned
// - Accesses start only on K edges
// - Inverted-K edges capture and launch too
// - Echo clocks run free, follow K
// - Write select low at K starts write, except on the K edge in the middle of a write burst or when read select is low on the same edge
// - Write data taken only during writes
module bsp_sram_port (
    input  wire logic                         i_clk,
    input  wire logic                         i_srst,
    input  wire logic                         i_ld_valid,
    input  wire logic [bsp_pkg::WADDR_W-1:0]  i_ld_addr,
    input  wire logic [bsp_pkg::DATA_W-1:0]   i_ld_data,
    output logic                              o_ld_ready,
    input  wire logic                         i_link_clk,
    input  wire logic                         i_k_phase,
    input  wire logic [bsp_pkg::ADDR_W-1:0]   i_addr,
    input  wire logic                         i_read_port_select_n,
    input  wire logic                         i_write_port_select_n,
    input  wire logic [bsp_pkg::DATA_W-1:0]   i_d,
    input  wire logic [bsp_pkg::LANES-1:0]    i_byte_lane_write_mask_n,
    output logic      [bsp_pkg::DATA_W-1:0]   o_q,
    output logic                              o_q_oe_n,
    output logic                              o_output_valid_flag,
    output logic                              o_echo_clock,
    output logic                              o_echo_clock_n
);
    // Each link clock edge stands for one rising edge of K or of
    // inverted K; i_k_phase says which (high means K). All link
    // pins are launched by the controller on this same clock, so
    // they are sampled directly with no synchroniser.

    // Link-domain reset, carried over from i_clk by two flops
    logic rst_m_q;                // First stage, read by rst_s_q only
    logic rst_s_q;                // Reset as seen by link logic

    // Read sequencer state
    bsp_pkg::bsp_rd_state_t        rd_state_q;  // Current read phase
    bsp_pkg::bsp_rd_state_t        rd_state_d;  // Next read phase
    logic [bsp_pkg::IDX_W-1:0]     rd_idx_q;    // Word of burst to launch
    logic [bsp_pkg::IDX_W-1:0]     rd_idx_d;    // Next word index
    logic [bsp_pkg::ADDR_W-1:0]    rd_addr_q;   // Captured read address

    // Write sequencer state
    bsp_pkg::bsp_wr_state_t        wr_state_q;  // Current write phase
    bsp_pkg::bsp_wr_state_t        wr_state_d;  // Next write phase
    logic [bsp_pkg::IDX_W-1:0]     wr_idx_q;    // Word of burst expected
    logic [bsp_pkg::IDX_W-1:0]     wr_idx_d;    // Next word index
    logic [bsp_pkg::ADDR_W-1:0]    wr_addr_q;   // Captured write address

    // Output registers
    logic [bsp_pkg::DATA_W-1:0]    q_q;         // Read data on the pins
    logic                          oe_n_q;      // Driver enable, low drives
    logic                          valid_q;     // Output valid flag
    logic                          echo_q;      // Echo clock
    logic                          echo_n_q;    // Inverted echo clock

    // The array: four words behind every pin address
    logic [bsp_pkg::DATA_W-1:0] mem [bsp_pkg::MEM_WORDS];

    // Crossing buffer for backdoor loads from the i_clk side
    bsp_buf_if #(.W(bsp_pkg::LD_W)) ld_bus ();

    bsp_cdc_fifo #(
        .W  (bsp_pkg::LD_W),
        .AW (bsp_pkg::FIFO_AW)
    ) u_ld_fifo (
        .i_wclk (i_clk),
        .i_wrst (i_srst),
        .i_rclk (i_link_clk),
        .i_rrst (rst_s_q),
        .bus    (ld_bus.buf_side)
    );

    // Load side: the user port feeds the buffer, back-pressure is direct
    assign ld_bus.fill_valid = i_ld_valid;
    assign ld_bus.fill_data  = {i_ld_addr, i_ld_data};
    assign o_ld_ready        = ld_bus.fill_ready;

    // Edge type and selects as decoded wires
    wire k_edge   = i_k_phase;
    wire rd_sel   = ~i_read_port_select_n;
    wire wr_sel   = ~i_write_port_select_n;

    // A read may begin when idle, in the tail, or on the last word
    wire rd_in_burst = (rd_state_q == bsp_pkg::RD_BURST);
    wire rd_last     = rd_in_burst & (rd_idx_q == bsp_pkg::IDX_LAST);
    wire rd_can      = ~rd_in_burst | rd_last;
    // Starts only on a K edge, never on an inverted-K edge
    wire rd_start    = k_edge & rd_sel & rd_can;

    // A write may begin when idle or while its last word lands
    wire wr_in_burst = (wr_state_q == bsp_pkg::WR_BURST);
    wire wr_last     = wr_in_burst & (wr_idx_q == bsp_pkg::IDX_LAST);
    wire wr_can      = ~wr_in_burst | wr_last;
    // The shared bus belongs to the read when both selects are low,
    // so the write port then ignores the address entirely
    wire wr_start    = k_edge & wr_sel & ~rd_sel & wr_can;

    // Data is stored only inside a live write burst; outside one
    // the data and mask pins are never looked at
    wire wr_store    = wr_in_burst;

    // Word addresses into the array
    wire [bsp_pkg::WADDR_W-1:0] rd_waddr = {rd_addr_q, rd_idx_q};
    wire [bsp_pkg::WADDR_W-1:0] wr_waddr = {wr_addr_q, wr_idx_q};

    // Array read ports: burst word and old word for the lane merge
    wire [bsp_pkg::DATA_W-1:0]  rd_word  = mem[rd_waddr];
    wire [bsp_pkg::DATA_W-1:0]  old_word = mem[wr_waddr];
    logic [bsp_pkg::DATA_W-1:0] wr_word;  // Merged word to store

    // Per-lane merge: a masked lane keeps the stored byte. The mask
    // is taken on the very edge that takes its data word.
    for (genvar l = 0; l < bsp_pkg::LANES; l++) begin : g_lane
        assign wr_word[l*bsp_pkg::LANE_W +: bsp_pkg::LANE_W] =
            i_byte_lane_write_mask_n[l]
                ? old_word[l*bsp_pkg::LANE_W +: bsp_pkg::LANE_W]
                : i_d[l*bsp_pkg::LANE_W +: bsp_pkg::LANE_W];
    end

    // Backdoor loads yield to pin writes, since the array has one
    // write port; a stalled load just waits in the buffer
    assign ld_bus.drain_ready = ~wr_store;
    wire ld_take = ld_bus.drain_valid & ~wr_store;
    wire [bsp_pkg::WADDR_W-1:0] ld_waddr =
        ld_bus.drain_data[bsp_pkg::LD_W-1 -: bsp_pkg::WADDR_W];
    wire [bsp_pkg::DATA_W-1:0]  ld_wdata =
        ld_bus.drain_data[bsp_pkg::DATA_W-1:0];

    // A burst word leaves the pins on every link edge of the burst,
    // both K and inverted K
    wire rd_launch = rd_in_burst;

    // Drivers stay on through the burst and the half cycle after it,
    // and go off only on the K edge that follows the last word
    wire in_tail  = (rd_state_q == bsp_pkg::RD_TAIL);
    wire drive_nx = rd_launch | (in_tail & ~k_edge);

    // Read sequencer next state
    always_comb begin
        rd_state_d = rd_state_q;
        rd_idx_d   = rd_idx_q;
        unique case (rd_state_q)
            bsp_pkg::RD_IDLE: begin
                // Waiting for a read select on a K edge
                if (rd_start) begin
                    rd_state_d = bsp_pkg::RD_BURST;
                    rd_idx_d   = bsp_pkg::IDX_FIRST;
                end
            end
            bsp_pkg::RD_BURST: begin
                // Four sequential words, then back-to-back or tail
                rd_idx_d = rd_idx_q + 2'h1;
                if (rd_last) begin
                    if (rd_start) begin
                        rd_idx_d = bsp_pkg::IDX_FIRST;
                    end else begin
                        rd_state_d = bsp_pkg::RD_TAIL;
                    end
                end
            end
            bsp_pkg::RD_TAIL: begin
                // Last word held until the next K edge
                if (rd_start) begin
                    rd_state_d = bsp_pkg::RD_BURST;
                    rd_idx_d   = bsp_pkg::IDX_FIRST;
                end else if (k_edge) begin
                    rd_state_d = bsp_pkg::RD_IDLE;
                end
            end
            default: begin
                // Unused code: fall back to idle
                rd_state_d = bsp_pkg::RD_IDLE;
            end
        endcase
    end

    // Write sequencer next state
    always_comb begin
        wr_state_d = wr_state_q;
        wr_idx_d   = wr_idx_q;
        unique case (wr_state_q)
            bsp_pkg::WR_IDLE: begin
                // Waiting for a write select on a K edge
                if (wr_start) begin
                    wr_state_d = bsp_pkg::WR_BURST;
                    wr_idx_d   = bsp_pkg::IDX_FIRST;
                end
            end
            bsp_pkg::WR_BURST: begin
                // The controller supplies one word per link edge
                wr_idx_d = wr_idx_q + 2'h1;
                if (wr_last) begin
                    if (wr_start) begin
                        wr_idx_d = bsp_pkg::IDX_FIRST;
                    end else begin
                        wr_state_d = bsp_pkg::WR_IDLE;
                    end
                end
            end
        endcase
    end

    // Reset crossing into the link domain
    always_ff @(posedge i_link_clk) begin
        rst_m_q <= i_srst;
        rst_s_q <= rst_m_q;
    end

    // Read sequencer registers
    always_ff @(posedge i_link_clk) begin
        if (rst_s_q) begin
            rd_state_q <= bsp_pkg::RD_IDLE;
            rd_idx_q   <= bsp_pkg::IDX_FIRST;
        end else begin
            rd_state_q <= rd_state_d;
            rd_idx_q   <= rd_idx_d;
        end
    end

    // Read address, taken from the shared bus on the K edge
    always_ff @(posedge i_link_clk) begin
        if (rst_s_q) begin
            rd_addr_q <= '0;
        end else if (rd_start) begin
            rd_addr_q <= i_addr;
        end
    end

    // Write sequencer registers
    always_ff @(posedge i_link_clk) begin
        if (rst_s_q) begin
            wr_state_q <= bsp_pkg::WR_IDLE;
            wr_idx_q   <= bsp_pkg::IDX_FIRST;
        end else begin
            wr_state_q <= wr_state_d;
            wr_idx_q   <= wr_idx_d;
        end
    end

    // Write address, taken from the shared bus on the K edge
    always_ff @(posedge i_link_clk) begin
        if (rst_s_q) begin
            wr_addr_q <= '0;
        end else if (wr_start) begin
            wr_addr_q <= i_addr;
        end
    end

    // Array write: pin burst first, otherwise one buffered load.
    // The array itself has no reset, as in the real part.
    always_ff @(posedge i_link_clk) begin
        if (wr_store) begin
            mem[wr_waddr] <= wr_word;
        end else if (ld_take) begin
            mem[ld_waddr] <= ld_wdata;
        end
    end

    // Read data register: updated only when a word is launched
    always_ff @(posedge i_link_clk) begin
        if (rst_s_q) begin
            q_q <= bsp_pkg::Q_RESET;
        end else if (rd_launch) begin
            q_q <= rd_word;
        end
    end

    // Driver enable and valid flag share the launch edge, so the
    // flag changes on the same link edges as the echo clocks
    always_ff @(posedge i_link_clk) begin
        if (rst_s_q) begin
            oe_n_q  <= 1'b1;
            valid_q <= 1'b0;
        end else begin
            oe_n_q  <= ~drive_nx;
            valid_q <= rd_launch;
        end
    end

    // Echo clocks follow K from every link edge and are left out of
    // reset on purpose, so they never stop while K runs
    always_ff @(posedge i_link_clk) begin
        echo_q   <= k_edge;
        echo_n_q <= ~k_edge;
    end

    assign o_q                 = q_q;
    assign o_q_oe_n            = oe_n_q;
    assign o_output_valid_flag = valid_q;
    assign o_echo_clock        = echo_q;
    assign o_echo_clock_n      = echo_n_q;
endmodule

// ### verification/bsp_sram_port_monitor.sv
// Concurrent checks on the link-side pins of the burst SRAM port
`timescale 1ns/1ps
module bsp_sram_port_monitor (
    input wire logic                       i_link_clk,
    input wire logic                       i_srst,
    input wire logic                       i_k_phase,
    input wire logic                       i_read_port_select_n,
    input wire logic [bsp_pkg::DATA_W-1:0] o_q,
    input wire logic                       o_q_oe_n,
    input wire logic                       o_output_valid_flag,
    input wire logic                       o_echo_clock,
    input wire logic                       o_echo_clock_n
);
    // All pins here belong to the link domain
    default clocking cb @(posedge i_link_clk); endclocking
    default disable iff (i_srst);

    // Echo pair tracks the previous edge phase
    a_echo_tracks_k: assert property (o_echo_clock == $past(i_k_phase))
        else $error("echo clock out of step with K");
    a_echo_pair_compl: assert property (o_echo_clock_n == !o_echo_clock)
        else $error("echo pair not complementary");
    // A burst only follows a read select on a K edge
    // The flag is first seen high two edges after the start edge
    a_read_start_k: assert property ($rose(o_output_valid_flag) |->
        $past(i_k_phase, 2) && !$past(i_read_port_select_n, 2))
        else $error("burst began without read select on K");
    a_burst_four_words: assert property ($rose(o_output_valid_flag) |->
        o_output_valid_flag [*4])
        else $error("burst shorter than four words");
    a_valid_while_driven: assert property (o_output_valid_flag |-> !o_q_oe_n)
        else $error("valid while outputs float");
    a_tail_holds_word: assert property ($fell(o_output_valid_flag) |->
        $stable(o_q) && !o_q_oe_n)
        else $error("tail lost last word");
    // Drivers let go at the next K edge, even when a new read starts there
    a_off_after_k: assert property ($fell(o_output_valid_flag) |-> ##1
        (o_q_oe_n && $past(i_k_phase)))
        else $error("drivers not released at next K");
    a_drive_needs_data: assert property ($fell(o_q_oe_n) |-> o_output_valid_flag)
        else $error("drivers on without data");
endmodule

// ### verification/bsp_ctl_model.sv
// Memory controller model driving the link pins of the SRAM port
`timescale 1ns/1ps
module bsp_ctl_model (
    input  wire logic                    i_link_clk,
    output logic                         o_k_phase,
    output logic [bsp_pkg::ADDR_W-1:0]   o_addr,
    output logic                         o_rps_n,
    output logic                         o_wps_n,
    output logic [bsp_pkg::DATA_W-1:0]   o_d,
    output logic [bsp_pkg::LANES-1:0]    o_mask_n
);
    // Idle pins
    initial begin
        o_k_phase = 1'b0;
        o_addr    = '0;
        o_rps_n   = 1'b1;
        o_wps_n   = 1'b1;
        o_d       = '0;
        o_mask_n  = '1;
    end
    // K and inverted K alternate on every link edge
    always @(posedge i_link_clk) o_k_phase <= ~o_k_phase;
    // Pass one edge; unused buses keep changing so stale values never match
    task automatic step();
        @(posedge i_link_clk);
        #1;
        o_d    = ~o_d;
        o_addr = ~o_addr;
    endtask
    // Wait until the coming edge carries phase k
    task automatic align(input logic k);
        step();
        while (o_k_phase !== k) step();
    endtask
    // Selects and address held for one edge only
    task automatic start(input logic k, input logic rd, input logic wr,
                         input logic [bsp_pkg::ADDR_W-1:0] a);
        align(k);
        o_rps_n = ~rd;
        o_wps_n = ~wr;
        o_addr  = a;
        step();
        o_rps_n = 1'b1;
        o_wps_n = 1'b1;
    endtask
    // Four words with their masks on the edges after the select
    task automatic burst(input logic [bsp_pkg::DATA_W-1:0] w [4],
                         input logic [bsp_pkg::LANES-1:0] m [4]);
        for (int k = 0; k < 4; k++) begin
            o_d      = w[k];
            o_mask_n = m[k];
            if (k < 3) step();
        end
        step();
        o_mask_n = '1;
    endtask
endmodule

// ### verification/testbench.sv
// Self-checking bench for the burst SRAM port
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module testbench;
    logic                         i_clk = 1'b0;
    logic                         i_link_clk = 1'b0;
    logic                         i_srst, i_ld_valid, o_ld_ready;
    logic [bsp_pkg::WADDR_W-1:0]  i_ld_addr;
    logic [bsp_pkg::DATA_W-1:0]   i_ld_data, o_q, i_d, ew;
    logic [bsp_pkg::ADDR_W-1:0]   i_addr;
    logic [bsp_pkg::LANES-1:0]    mask_n;
    logic                         k_ph, rps_n, wps_n, oe_n, vld, ec, ec_n, saw_full;
    logic [bsp_pkg::DATA_W-1:0]   mem [logic [bsp_pkg::WADDR_W-1:0]]; // Reference array
    logic [bsp_pkg::DATA_W-1:0]   exp_q [$]; // Words still owed
    int                           n_fail = 0, samples_checked = 0, cyc = 0;

    always #20 i_clk = ~i_clk;
    // Link clock offset so its edges never meet the system clock
    initial begin
        #7;
        forever #40 i_link_clk = ~i_link_clk;
    end

    bsp_sram_port DUT (.i_clk(i_clk), .i_srst(i_srst), .i_ld_valid(i_ld_valid),
        .i_ld_addr(i_ld_addr), .i_ld_data(i_ld_data), .o_ld_ready(o_ld_ready),
        .i_link_clk(i_link_clk), .i_k_phase(k_ph), .i_addr(i_addr),
        .i_read_port_select_n(rps_n), .i_write_port_select_n(wps_n), .i_d(i_d),
        .i_byte_lane_write_mask_n(mask_n), .o_q(o_q), .o_q_oe_n(oe_n),
        .o_output_valid_flag(vld), .o_echo_clock(ec), .o_echo_clock_n(ec_n));
    bsp_ctl_model ctl (.i_link_clk(i_link_clk), .o_k_phase(k_ph), .o_addr(i_addr),
        .o_rps_n(rps_n), .o_wps_n(wps_n), .o_d(i_d), .o_mask_n(mask_n));

    function automatic logic [bsp_pkg::DATA_W-1:0] rw();
        return bsp_pkg::DATA_W'({$urandom(), $urandom()});
    endfunction
    // Four backdoor words back to back; ready may refuse meanwhile
    task automatic fill(input logic [bsp_pkg::ADDR_W-1:0] a);
        logic [bsp_pkg::DATA_W-1:0] w;
        @(posedge i_clk);
        for (int k = 0; k < 4; k++) begin
            w = rw();
            i_ld_valid <= 1'b1;
            i_ld_addr  <= {a, 2'(k)};
            i_ld_data  <= w;
            @(negedge i_clk);
            while (o_ld_ready !== 1'b1) begin
                saw_full = 1'b1;
                @(negedge i_clk);
            end
            @(posedge i_clk);
            mem[{a, 2'(k)}] = w;
        end
        i_ld_valid <= 1'b0;
    endtask
    // Read; ign_wr also pulls write select low on the same edge
    task automatic rd(input logic [bsp_pkg::ADDR_W-1:0] a, input logic ign_wr);
        for (int k = 0; k < 4; k++) exp_q.push_back(mem[{a, 2'(k)}]);
        ctl.start(1'b1, 1'b1, ign_wr, a);
        repeat (3) ctl.step();
    endtask
    // Masked write; k_ok=0 puts the select on an inverted-K edge
    task automatic wr(input logic [bsp_pkg::ADDR_W-1:0] a, input logic rnd,
                      input logic k_ok);
        logic [bsp_pkg::DATA_W-1:0] w [4];
        logic [bsp_pkg::LANES-1:0]  m [4];
        for (int k = 0; k < 4; k++) begin
            w[k] = rw();
            m[k] = rnd ? 4'($urandom()) : ~(4'h1 << k);
            for (int j = 0; j < 4; j++)
                if (k_ok && !m[k][j]) mem[{a, 2'(k)}][j*9 +: 9] = w[k][j*9 +: 9];
        end
        ctl.start(k_ok, 1'b0, 1'b1, a);
        ctl.burst(w, m);
    endtask

    // Compare every burst word with the oldest note
    always @(posedge i_link_clk) begin
        #2;
        if (vld === 1'b1) begin
            ew = (exp_q.size() > 0) ? exp_q.pop_front() : ~o_q;
            `CHK("read word", ew, o_q)
        end
    end
    // Hang guard
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            results();
        end
    end

    task automatic results();
        $display("checks %0d errors %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        void'($urandom(54));
        i_srst = 1'b1;
        i_ld_valid = 1'b0;
        i_ld_addr = '0;
        i_ld_data = '0;
        saw_full = 1'b0;
        repeat (12) @(posedge i_clk);
        i_srst <= 1'b0;
        repeat (4) @(posedge i_link_clk);
        fill(17'h00000);
        fill(17'h1FFFF);
        fill(17'h00ABC);
        repeat (10) @(posedge i_link_clk);
        rd(17'h00000, 1'b0);
        wr(17'h1FFFF, 1'b0, 1'b1);
        rd(17'h1FFFF, 1'b0);
        wr(17'h00000, 1'b0, 1'b0);
        rd(17'h00000, 1'b1);
        // Gapless pair: second start on the fourth edge
        for (int k = 0; k < 4; k++) exp_q.push_back(mem[{17'h00ABC, 2'(k)}]);
        ctl.start(1'b1, 1'b1, 1'b0, 17'h00ABC);
        ctl.step();
        ctl.step();
        rd(17'h1FFFF, 1'b0);
        // Mid-burst select is refused
        for (int k = 0; k < 4; k++) exp_q.push_back(mem[{17'h00ABC, 2'(k)}]);
        ctl.start(1'b1, 1'b1, 1'b0, 17'h00ABC);
        ctl.start(1'b1, 1'b1, 1'b0, 17'h00000);
        repeat (4) ctl.step();
        // Loads stall behind pin writes
        fork
            wr(17'h00ABC, 1'b1, 1'b1);
            fill(17'h00123);
        join
        repeat (10) @(posedge i_link_clk);
        rd(17'h00ABC, 1'b0);
        rd(17'h00123, 1'b0);
        repeat (12) @(posedge i_link_clk);
        `CHK("load refused when full", 1'b1, saw_full)
        `CHK("words left", 0, exp_q.size())
        // Second reset: outputs quiet, echo pair stays complementary
        @(posedge i_clk);
        i_srst <= 1'b1;
        repeat (12) @(posedge i_clk);
        `CHK("oe_n in reset", 1'b1, oe_n)
        `CHK("valid in reset", 1'b0, vld)
        `CHK("echo pair", ~ec, ec_n)
        i_srst <= 1'b0;
        repeat (4) @(posedge i_link_clk);
        fill(17'h0F0F0);
        repeat (10) @(posedge i_link_clk);
        rd(17'h0F0F0, 1'b0);
        repeat (12) @(posedge i_link_clk);
        `CHK("words left", 0, exp_q.size())
        results();
    end
endmodule

bind bsp_sram_port bsp_sram_port_monitor u_mon (.i_link_clk(i_link_clk), .i_srst(i_srst),
    .i_k_phase(i_k_phase), .i_read_port_select_n(i_read_port_select_n), .o_q(o_q),
    .o_q_oe_n(o_q_oe_n), .o_output_valid_flag(o_output_valid_flag),
    .o_echo_clock(o_echo_clock), .o_echo_clock_n(o_echo_clock_n));
